// >>> verilog/ixadd_pkg.sv
// Constants shared by the index address adder
// Summary of operation
// - Each position forms the exclusive OR of its A and B inputs.
// - Sum is that exclusive OR with the incoming carry; carry touches only sum.
// - Propagate is high when A or B is one.
// - Generate is high only when A and B are both one.
// - Fifteen positions form three groups of five: 17-13, 12-8, 7-3.
// - Carries inside a group come from lookahead over lower positions, not ripple.
// - Position 12 gets its carry only from group lookahead.
// - Group lookahead decides carries into low positions of groups two and three.
// - Top carry out is combinational group lookahead from all three groups.
// - All lookahead uses position inputs only, never formed carries.
// - Top carry out serves as success for index transfer tests.
// - Memory-nullify forces position 3 to propagate.
// - Memory-nullify blocks the sum of position 3.
// - With the 24K split, position 4 also propagates and its sum is blocked.
// - Ones on all B decrement A; one on B position 17 increments A.
// - Zero tag: all-ones B plus carry into 17 leaves A unchanged.
// - A free-running latch captures the full result on every rising clock while I_RST_N is high; a low I_RST_N clears it on the clock.
// - A group passes a carry when generating, or propagating a lower carry.
package ixadd_pkg;
   localparam int IXADD_WIDTH  = 15;
   localparam int IXADD_GROUPS = 3;
   localparam int IXADD_GSIZE  = 5;
   // Vector index of positions 3 and 4 (index 0 is position 17)
   localparam int IXADD_POS3   = 14;
   localparam int IXADD_POS4   = 13;
   localparam logic [14:0] IXADD_ZERO = 15'h0000;
   localparam logic [14:0] IXADD_ONES = 15'h7fff;
   localparam logic [14:0] IXADD_ONE  = 15'h0001;
endpackage

// >>> verilog/ixadd_group.sv
// One five-position lookahead group of the index adder
module ixadd_group
   import ixadd_pkg::*;
#(
   parameter int N = IXADD_GSIZE
)(
   input  wire logic [N-1:0] i_a,
   input  wire logic [N-1:0] i_b,
   input  wire logic [N-1:0] i_force_p,
   input  wire logic         i_cin,
   output logic [N-1:0]      o_sum,
   output logic              o_any_gen,
   output logic              o_gen_or_prop
);
   logic [N-1:0] xo;
   logic [N-1:0] p;
   logic [N-1:0] g;
   logic [N-1:0] c;

   assign xo = i_a ^ i_b;
   assign p  = i_a | i_b | i_force_p;
   assign g  = i_a & i_b;

   always_comb
   begin
      c = '0;
      for (int k = 0; k < N; k++)
      begin
         logic t;
         logic pp;
         t  = i_cin;
         pp = 1'b1;
         for (int j = k - 1; j >= 0; j--)
         begin
            t  = t & p[j];
         end
         for (int j = k - 1; j >= 0; j--)
         begin
            t  = t | (g[j] & pp);
            pp = pp & p[j];
         end
         c[k] = t;
      end
   end
   assign o_sum = (xo & ~i_force_p) ^ (c & ~i_force_p);

   always_comb
   begin
      logic pp;
      pp            = 1'b1;
      o_any_gen     = |g;
      o_gen_or_prop = &p;
      for (int j = N - 1; j >= 1; j--)
      begin
         o_gen_or_prop = o_gen_or_prop | (g[j] & pp);
         pp = pp & p[j];
      end
   end
endmodule

// >>> verilog/ixadd_top.sv
// Index address adder with free-running result latch
module ixadd_top
   import ixadd_pkg::*;
(
   input  wire logic                   I_MCLK,
   input  wire logic                   I_RST_N,
   input  wire logic [IXADD_WIDTH-1:0] I_OPER_A,
   input  wire logic [IXADD_WIDTH-1:0] I_OPER_B,
   input  wire logic                   I_CARRY_IN,
   input  wire logic                   I_MEM_NULL,
   input  wire logic                   I_SPLIT_24K,
   output logic [IXADD_WIDTH-1:0]      O_RESULT,
   output logic                        O_TOP_CARRY
);
   typedef struct packed
   {
      logic [IXADD_WIDTH-1:0] result;
      logic                   carry;
   } ixadd_state_s;

   ixadd_state_s st_q;
   ixadd_state_s st_d;

   logic [IXADD_WIDTH-1:0]  force_p;
   logic [IXADD_WIDTH-1:0]  sum;
   logic [IXADD_GROUPS-1:0] any_gen;
   logic [IXADD_GROUPS-1:0] gen_or_prop;
   logic [IXADD_GROUPS:0]   gcin;
   logic                    adder_top_carry_out;
   logic [IXADD_WIDTH:0]    ref_c;
   logic [IXADD_WIDTH-1:0]  ref_sum;

   ////////////////////////////////////////////////////////////////////////
   // bypass forcing
   always_comb
   begin
      force_p = IXADD_ZERO;
      force_p[IXADD_POS3] = I_MEM_NULL;
      force_p[IXADD_POS4] = I_SPLIT_24K;
   end

   ////////////////////////////////////////////////////////////////////////
   // three groups of five
   genvar gi;
   generate
      for (gi = 0; gi < IXADD_GROUPS; gi++)
      begin : g_grp
         ixadd_group #(.N(IXADD_GSIZE)) u_grp (
            .i_a           (I_OPER_A[gi*IXADD_GSIZE +: IXADD_GSIZE]),
            .i_b           (I_OPER_B[gi*IXADD_GSIZE +: IXADD_GSIZE]),
            .i_force_p     (force_p[gi*IXADD_GSIZE +: IXADD_GSIZE]),
            .i_cin         (gcin[gi]),
            .o_sum         (sum[gi*IXADD_GSIZE +: IXADD_GSIZE]),
            .o_any_gen     (any_gen[gi]),
            .o_gen_or_prop (gen_or_prop[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // group lookahead and top carry
   always_comb
   begin
      gcin[0] = I_CARRY_IN;
      for (int k = 1; k <= IXADD_GROUPS; k++)
      begin
         logic t;
         t = I_CARRY_IN;
         for (int j = 0; j < k; j++)
         begin
            t = (t | any_gen[j]) & gen_or_prop[j];
         end
         gcin[k] = t;
      end
      adder_top_carry_out = gcin[IXADD_GROUPS];
   end

   ////////////////////////////////////////////////////////////////////////
   // blocked sums, plain binary add
   always_comb
   begin
      st_d        = st_q;
      st_d.result = sum;
      st_d.carry  = adder_top_carry_out;
   end

   always_ff @(posedge I_MCLK)
   begin
      if (!I_RST_N)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign O_RESULT    = st_q.result;
   assign O_TOP_CARRY = st_q.carry;

   ////////////////////////////////////////////////////////////////////////
   // Ripple reference for the checks only
   always_comb
   begin
      ref_c    = '0;
      ref_sum  = IXADD_ZERO;
      ref_c[0] = I_CARRY_IN;
      for (int i = 0; i < IXADD_WIDTH; i++)
      begin
         ref_sum[i] = (I_OPER_A[i] ^ I_OPER_B[i] ^ ref_c[i]) & ~force_p[i];
         ref_c[i+1] = (I_OPER_A[i] & I_OPER_B[i])
            | ((I_OPER_A[i] | I_OPER_B[i] | force_p[i]) & ref_c[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // latch follows adder
   chk_latch_follow: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> O_RESULT == $past(sum))
      else $error("result latch missed adder output");
   chk_null_block: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL |=> !O_RESULT[IXADD_POS3])
      else $error("position 3 sum not blocked");
   chk_split_block: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_SPLIT_24K |=> !O_RESULT[IXADD_POS4])
      else $error("position 4 sum not blocked");
   chk_sum_value: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_MEM_NULL && !I_SPLIT_24K |=> {O_TOP_CARRY, O_RESULT} ==
      16'({1'b0, $past(I_OPER_A)} + {1'b0, $past(I_OPER_B)} + 16'($past(I_CARRY_IN))))
      else $error("adder sum wrong");
   chk_zero_tag: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONES && I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |=> O_RESULT == $past(I_OPER_A) && O_TOP_CARRY)
      else $error("zero tag changed operand");
   chk_increment: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONE && !I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |=> O_RESULT == 15'($past(I_OPER_A) + IXADD_ONE))
      else $error("increment wrong");
   chk_null_carry: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL && !I_SPLIT_24K && !I_OPER_A[IXADD_POS3] && !I_OPER_B[IXADD_POS3]
      |=> O_TOP_CARRY == $past(sum[IXADD_POS4] != (I_OPER_A[IXADD_POS4]
      ^ I_OPER_B[IXADD_POS4]) ? (I_OPER_A[IXADD_POS4] | I_OPER_B[IXADD_POS4])
      : (I_OPER_A[IXADD_POS4] & I_OPER_B[IXADD_POS4])))
      else $error("carry not passed through position 3");
   chk_grp2_cin: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      gcin[1] == (16'({1'b0, I_OPER_A[4:0]} + {1'b0, I_OPER_B[4:0]} +
      16'(I_CARRY_IN)) > 16'h001f))
      else $error("group two carry wrong");

   ////////////////////////////////////////////////////////////////////////
   // exclusive OR term
   chk_xor_low: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_CARRY_IN |-> sum[0] == (I_OPER_A[0] ^ I_OPER_B[0]))
      else $error("position 17 exclusive OR wrong");
   chk_xor_top: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_MEM_NULL && !ref_c[IXADD_POS3]
      |-> sum[IXADD_POS3] == (I_OPER_A[IXADD_POS3] ^ I_OPER_B[IXADD_POS3]))
      else $error("position 3 exclusive OR wrong");
   chk_carry_sum: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      sum[0] == (I_OPER_A[0] ^ I_OPER_B[0] ^ I_CARRY_IN))
      else $error("position 17 sum ignores carry");
   chk_carry_only: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_OPER_A[0] && !I_OPER_B[0] |-> sum[1] == (I_OPER_A[1] ^ I_OPER_B[1]))
      else $error("carry leaked past idle position");
   chk_prop_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_CARRY_IN && (I_OPER_A[0] || I_OPER_B[0]) |-> sum[1] != (I_OPER_A[1] ^ I_OPER_B[1]))
      else $error("propagate did not pass carry");
   chk_prop_top: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      ref_c[IXADD_POS3] && (I_OPER_A[IXADD_POS3] || I_OPER_B[IXADD_POS3] || I_MEM_NULL)
      |-> adder_top_carry_out)
      else $error("top propagate lost carry");
   chk_gen_both: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_A[0] && I_OPER_B[0] |-> sum[1] != (I_OPER_A[1] ^ I_OPER_B[1]))
      else $error("generate missing");
   chk_gen_only: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_CARRY_IN && !(I_OPER_A[0] && I_OPER_B[0]) |-> sum[1] == (I_OPER_A[1] ^ I_OPER_B[1]))
      else $error("generate without both ones");
   chk_gen_top: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_A[IXADD_POS3] && I_OPER_B[IXADD_POS3] |-> adder_top_carry_out)
      else $error("top generate missing");

   ////////////////////////////////////////////////////////////////////////
   // group three low position
   chk_grp3_low: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      sum[2*IXADD_GSIZE] ==
      (I_OPER_A[2*IXADD_GSIZE] ^ I_OPER_B[2*IXADD_GSIZE] ^ gcin[2]))
      else $error("group three low sum wrong");
   chk_bit_sum: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      sum == ref_sum)
      else $error("position sums wrong");
   chk_pos12_cin: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      sum[IXADD_GSIZE] == (I_OPER_A[IXADD_GSIZE] ^ I_OPER_B[IXADD_GSIZE] ^ gcin[1]))
      else $error("position 12 carry not from group lookahead");
   chk_grp2_ref: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      gcin[1] == ref_c[IXADD_GSIZE])
      else $error("carry into group two wrong");
   chk_grp3_ref: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      gcin[2] == ref_c[2*IXADD_GSIZE])
      else $error("carry into group three wrong");
   chk_top_ref: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      adder_top_carry_out == ref_c[IXADD_WIDTH])
      else $error("top carry wrong");
   chk_ones_carry: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      (I_OPER_A | I_OPER_B) == IXADD_ONES && I_CARRY_IN |-> adder_top_carry_out)
      else $error("full propagate lost carry");
   chk_grp3_stop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !gen_or_prop[2] |-> !adder_top_carry_out)
      else $error("top carry without group three propagate");
   chk_grp3_gen: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      any_gen[2] && gen_or_prop[2] |-> adder_top_carry_out)
      else $error("group three generate lost");
   chk_zero_none: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_A == IXADD_ZERO && I_OPER_B == IXADD_ZERO |-> !adder_top_carry_out)
      else $error("top carry with no operand bits");
   chk_top_latch: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> O_TOP_CARRY == $past(adder_top_carry_out))
      else $error("latched top carry wrong");

   ////////////////////////////////////////////////////////////////////////
   // group generate passes
   chk_grp_gen: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      any_gen[1] && gen_or_prop[1] |-> gcin[2])
      else $error("group two generate not passed");
   chk_grp_prop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      gcin[1] && gen_or_prop[1] |-> gcin[2])
      else $error("group two propagate not passed");
   chk_grp_stop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !gen_or_prop[1] |-> !gcin[2])
      else $error("group two passed carry without propagate");
   chk_grp1_idle: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !any_gen[0] && !I_CARRY_IN |-> !gcin[1])
      else $error("group one carry from nothing");
   chk_grp1_stop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !gen_or_prop[0] |-> !gcin[1])
      else $error("group one passed carry without propagate");
   chk_grp3_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      gcin[2] && gen_or_prop[2] |-> adder_top_carry_out)
      else $error("group three propagate not passed");

   ////////////////////////////////////////////////////////////////////////
   // position 3 sum blocked
   chk_null_sum: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL |-> !sum[IXADD_POS3])
      else $error("position 3 adder sum not blocked");
   chk_null_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL && !I_OPER_A[IXADD_POS3] && !I_OPER_B[IXADD_POS3]
      |-> adder_top_carry_out == ref_c[IXADD_POS3])
      else $error("position 4 carry not at top");
   chk_null_gen: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL && I_OPER_A[IXADD_POS3] && I_OPER_B[IXADD_POS3] |-> adder_top_carry_out)
      else $error("forced position 3 lost generate");
   chk_split_sum: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_SPLIT_24K |-> !sum[IXADD_POS4])
      else $error("position 4 adder sum not blocked");
   chk_split_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_SPLIT_24K && !I_MEM_NULL && !I_OPER_A[IXADD_POS4] && !I_OPER_B[IXADD_POS4]
      |-> sum[IXADD_POS3] ==
      (I_OPER_A[IXADD_POS3] ^ I_OPER_B[IXADD_POS3] ^ ref_c[IXADD_POS4]))
      else $error("carry not passed through position 4");
   chk_both_block: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL && I_SPLIT_24K |-> sum[IXADD_POS3:IXADD_POS4] == 2'h0)
      else $error("positions 3 and 4 not both blocked");
   chk_both_pass: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_MEM_NULL && I_SPLIT_24K && !(I_OPER_A[IXADD_POS3] | I_OPER_B[IXADD_POS3])
      && !(I_OPER_A[IXADD_POS4] | I_OPER_B[IXADD_POS4])
      |-> adder_top_carry_out == ref_c[IXADD_POS4])
      else $error("carry not passed through positions 3 and 4");

   ////////////////////////////////////////////////////////////////////////
   // decrement value
   chk_decrement: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONES && !I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |=> O_RESULT == 15'($past(I_OPER_A) - IXADD_ONE))
      else $error("decrement wrong");
   chk_dec_carry: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONES && !I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |=> O_TOP_CARRY == ($past(I_OPER_A) != IXADD_ZERO))
      else $error("decrement carry wrong");
   chk_inc_carry: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONE && !I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |=> O_TOP_CARRY == ($past(I_OPER_A) == IXADD_ONES))
      else $error("increment carry wrong");
   chk_zero_carry: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_OPER_B == IXADD_ONES && I_CARRY_IN && !I_MEM_NULL && !I_SPLIT_24K
      |-> adder_top_carry_out)
      else $error("zero tag carry missing");
   chk_result_ref: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> O_RESULT == $past(ref_sum))
      else $error("latched result wrong");
   chk_reset_clear: assert property (@(posedge I_MCLK)
      !I_RST_N |=> O_RESULT == IXADD_ZERO && !O_TOP_CARRY)
      else $error("latch not cleared by reset");
endmodule

// >>> tb/ixadd_seq.sv
// Operand gating sequencer model feeding the index adder
module ixadd_seq
   import ixadd_pkg::*;
(
   output logic [IXADD_WIDTH-1:0] o_a,
   output logic [IXADD_WIDTH-1:0] o_b,
   output logic                   o_cin,
   output logic                   o_mnull,
   output logic                   o_split
);
   timeunit 1ns;
   timeprecision 1ns;
   task send(logic [14:0] a, b, logic c, n, p);
      o_a = a;
      o_b = b;
      {o_cin, o_mnull, o_split} = {c, n, p};
   endtask
endmodule

// >>> tb/index_address_adder_bench.sv
// Self-checking bench for the index address adder
module index_address_adder_bench
   import ixadd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        rst_n;
   logic [14:0] a, b, res;
   logic        c, m, s, top;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   always #50 mclk = ~mclk;
   ixadd_seq SEQ (.o_a(a), .o_b(b), .o_cin(c), .o_mnull(m), .o_split(s));
   ixadd_top DUT (.I_MCLK(mclk), .I_RST_N(rst_n), .I_OPER_A(a), .I_OPER_B(b),
      .I_CARRY_IN(c), .I_MEM_NULL(m), .I_SPLIT_24K(s), .O_RESULT(res),
      .O_TOP_CARRY(top));
   ////////////////////////////////////////
   function automatic logic [15:0] ref_add(logic [14:0] x, y, logic k, n, p);
      logic [15:0] r;
      logic        f;
      for (int i = 0; i < 15; i++)
      begin
         f = (n && i == IXADD_POS3) || (p && i == IXADD_POS4);
         r[i] = f ? 1'b0 : x[i] ^ y[i] ^ k;
         k = (x[i] & y[i]) | ((x[i] | y[i] | f) & k);
      end
      r[15] = k;
      return r;
   endfunction
   task cmp(logic [15:0] e);
      checked++;
      if ({top, res} !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, {top, res}, e);
      end
   endtask
   task go(logic [14:0] x, y, logic k = 1'b0, n = 1'b0, p = 1'b0);
      SEQ.send(x, y, k, n, p);
      @(negedge mclk);
      cmp(ref_add(x, y, k, n, p));
   endtask
   task give_verdict;
      $display("Mismatches %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   task t_reset;
      rst_n = 1'b0;
      SEQ.send(IXADD_ONES, IXADD_ONES, 1'b1, 1'b0, 1'b0);
      repeat (6) @(negedge mclk);
      cmp(16'h0000);
      rst_n = 1'b1;
   endtask
   task t_terms;
      go(15'h0001, 15'h0000);
      go(15'h0001, 15'h0001);
      go(15'h0000, 15'h0000, 1'b1);
      go(15'h5555, 15'h3333, 1'b1);
   endtask
   task t_groups;
      go(15'h001f, 15'h0001);
      go(15'h0010, 15'h0010);
      go(15'h03e0, 15'h0020);
      go(15'h03ff, 15'h0000, 1'b1);
      go(15'h7fff, 15'h0001);
      go(15'h7c00, 15'h0400);
      go(15'h4000, 15'h4000);
      go(15'h0421, 15'h0c63);
   endtask
   task t_ones;
      go(15'h1234, IXADD_ONES);
      go(15'h7ffe, IXADD_ONE);
      go(15'h0000, IXADD_ONES, 1'b1);
      go(15'h2a5c, IXADD_ONES, 1'b1);
   endtask
   task t_bypass;
      go(15'h3fff, 15'h0001, 1'b0, 1'b1);
      go(15'h4000, 15'h0000, 1'b0, 1'b1);
      go(15'h1fff, 15'h0001, 1'b0, 1'b0, 1'b1);
      go(15'h6000, 15'h2000, 1'b0, 1'b1, 1'b1);
      go(15'h1fff, 15'h0001, 1'b0, 1'b1, 1'b1);
   endtask
   task t_latch;
      go(15'h7fff, 15'h7fff);
      go(15'h0000, 15'h0000);
   endtask
   ////////////////////////////////////////
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 200)
      begin
         err_count++;
         give_verdict;
      end
   end
   initial
   begin
      t_reset;
      t_terms;
      t_groups;
      t_ones;
      t_bypass;
      t_latch;
      t_reset;
      t_groups;
      give_verdict;
   end
endmodule
